// ---- src/bor_params.svh ----
`ifndef BOR_PARAMS_SVH
`define BOR_PARAMS_SVH

// register byte offset inside the host controller space
`define BOR_OFF_OPTIONS   8'h20

// field positions inside the options quadlet
`define BOR_BIT_IRM       31
`define BOR_BIT_CM        30
`define BOR_BIT_ISO       29
`define BOR_BIT_BM        28
`define BOR_BIT_PM        27
`define BOR_ACC_MSB       23
`define BOR_ACC_LSB       16
`define BOR_REC_MSB       15
`define BOR_REC_LSB       12
`define BOR_GEN_MSB       7
`define BOR_GEN_LSB       6
`define BOR_SPD_MSB       2
`define BOR_SPD_LSB       0

// reset values
`define BOR_RST_FLAG      1'b0
`define BOR_RST_ACC       8'h00
`define BOR_RST_REC       4'hb
`define BOR_RST_GEN       2'h0
`define BOR_RST_RSV3      3'h0
`define BOR_RST_RSV4      4'h0
`define BOR_LINK_SPEED    3'h3

// bus timing: ack follows the request by one edge
`define BOR_ACK_LAT       1

`endif

// ---- src/bor_pkg.sv ----
package bor_pkg;

  // layout of the options quadlet, msb first
  typedef struct packed {
    logic       irm_cap;    // isochronous resource manager capable
    logic       cm_cap;     // cycle master capable
    logic       iso_cap;    // isochronous capable
    logic       bm_cap;     // bus manager capable
    logic       pm_cap;     // power management capable
    logic [2:0] rsv_hi;     // always zero
    logic [7:0] clk_acc;    // cycle master accuracy, ppm
    logic [3:0] max_rec;    // block request size code
    logic [3:0] rsv_mid;    // always zero
    logic [1:0] gen;        // generation counter
    logic [2:0] rsv_lo;     // always zero
    logic [2:0] link_spd;   // fixed link speed code
  } bor_opts_t;

  // block write request offered for length checking
  typedef struct packed {
    logic        valid;     // request present this cycle
    logic [16:0] len;       // payload length in bytes
  } bor_req_t;

  // verdict on a block write request
  typedef struct packed {
    logic valid;            // verdict present this cycle
    logic type_err;         // length above the byte limit
  } bor_verdict_t;

  // wishbone slave states, one-hot
  typedef enum logic [1:0] {
    BS_IDLE = 2'b01,
    BS_ACK  = 2'b10
  } bor_bus_st_t;

endpackage : bor_pkg

// ---- src/bor_top.sv ----
`include "bor_params.svh"

module bor_top
#(
  parameter int          ADR_W   = 8,             // byte address width
  parameter logic [3:0]  REC_RST = `BOR_RST_REC   // size code after reset
)(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               soft_rst_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [ADR_W-1:0]   adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  input  wire bor_pkg::bor_req_t  req_i,
  output bor_pkg::bor_verdict_t   verdict_o,
  output logic      [31:0]        quadlet_o,
  output logic      [16:0]        rec_bytes_o
);

  import bor_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the decode needs the full offset, and codes below 8 are unusable
  generate
    if (ADR_W < 6)
    begin : g_bad_adr
      $error("address too narrow for the register offset");
    end
    if (REC_RST < 4'h8)
    begin : g_bad_rec
      $error("reset size code gives a limit under 512 bytes");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte limit for a size code: 2^(code+1)
  function automatic logic [16:0] rec_limit(input logic [3:0] code);
    logic [16:0] lim;
    lim = 17'h00001 << (code + 5'h01);
    return lim;
  endfunction : rec_limit

  // merge new data into old under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  bor_bus_st_t  st_q;          // wishbone slave state
  bor_bus_st_t  st_d;
  logic [31:0]  rdat_q;        // read data, held with ack
  logic [31:0]  rdat_d;
  bor_opts_t    opts_q;        // stored options fields
  bor_opts_t    opts_d;
  bor_opts_t    opts_wr;       // options as a write would leave them
  bor_verdict_t verd_q;        // length verdict
  bor_verdict_t verd_d;
  logic         req_live;      // request waiting, not yet acked
  logic         hit;           // address decodes to the options word
  logic [31:0]  wr_word;       // merged write value

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // any access inside the options word hits, whatever the low two address bits
  assign req_live = cyc_i && stb_i && (st_q == BS_IDLE);
  assign hit      = (adr_i[ADR_W-1:2] == (ADR_W-2)'(`BOR_OFF_OPTIONS >> 2));
  assign wr_word  = merge(opts_q, dat_i, sel_i);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: next state

  // ack one edge after the request, then drop for one cycle so a
  // master holding stb through ack is never answered twice
  always_comb
  begin
    st_d   = st_q;
    rdat_d = rdat_q;
    unique case (st_q)
      BS_IDLE:
      begin
        if (req_live)
        begin
          st_d = BS_ACK;
          // unmapped or write reads back as zero
          if (hit && !we_i)
          begin
            rdat_d = opts_q;
          end
          else
          begin
            rdat_d = 32'h0000_0000;
          end
        end
      end
      BS_ACK:
      begin
        st_d = BS_IDLE;
      end
    endcase
  end

  // wishbone slave: registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= BS_IDLE;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      st_q   <= st_d;
      rdat_q <= rdat_d;
    end
  end

  assign ack_o = (st_q == BS_ACK);
  assign dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // options register: next value

  // writes land on the edge of the ack, read-only fields are forced
  always_comb
  begin
    opts_wr          = wr_word;
    opts_wr.rsv_hi   = `BOR_RST_RSV3;
    opts_wr.rsv_mid  = `BOR_RST_RSV4;
    opts_wr.rsv_lo   = `BOR_RST_RSV3;
    opts_wr.link_spd = `BOR_LINK_SPEED;
    opts_d           = opts_q;
    // soft reset clears the flags, accuracy and generation, keeping the size code
    if (soft_rst_i)
    begin
      opts_d.irm_cap = `BOR_RST_FLAG;
      opts_d.cm_cap  = `BOR_RST_FLAG;
      opts_d.iso_cap = `BOR_RST_FLAG;
      opts_d.bm_cap  = `BOR_RST_FLAG;
      opts_d.pm_cap  = `BOR_RST_FLAG;
      opts_d.clk_acc = `BOR_RST_ACC;
      opts_d.gen     = `BOR_RST_GEN;
      // size code left as it is
      opts_d.max_rec = opts_q.max_rec;
    end
    else if (req_live && hit && we_i)
    begin
      // every rw field in an enabled byte takes the host value, including the size code
      opts_d = opts_wr;
    end
  end

  // options register: storage, hardware reset to 0000_b003
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      opts_q.irm_cap  <= `BOR_RST_FLAG;
      opts_q.cm_cap   <= `BOR_RST_FLAG;
      opts_q.iso_cap  <= `BOR_RST_FLAG;
      opts_q.bm_cap   <= `BOR_RST_FLAG;
      opts_q.pm_cap   <= `BOR_RST_FLAG;
      opts_q.rsv_hi   <= `BOR_RST_RSV3;
      opts_q.clk_acc  <= `BOR_RST_ACC;
      opts_q.max_rec  <= REC_RST;
      opts_q.rsv_mid  <= `BOR_RST_RSV4;
      // generation is undefined after reset; zero is chosen
      opts_q.gen      <= `BOR_RST_GEN;
      opts_q.rsv_lo   <= `BOR_RST_RSV3;
      opts_q.link_spd <= `BOR_LINK_SPEED;
    end
    else
    begin
      opts_q <= opts_d;
    end
  end

  // same flops feed the remote bus info block view
  assign quadlet_o   = opts_q;
  // no check on the code: a limit under 512 is software's fault
  assign rec_bytes_o = rec_limit(opts_q.max_rec);

  ////////////////////////////////////////////////////////////////////////////
  // block write length check: next value

  // verdict one edge after the request, against the current code
  always_comb
  begin
    verd_d.valid    = req_i.valid;
    verd_d.type_err = req_i.valid && (req_i.len > rec_limit(opts_q.max_rec));
  end

  // length check: registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      verd_q <= '0;
    end
    else
    begin
      verd_q <= verd_d;
    end
  end

  assign verdict_o = verd_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  // reset leaves the documented pattern; generation bits are not checked
  property p_rst_val;
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> (quadlet_o[31:8] == {16'h0000, REC_RST, 4'h0})
      && (quadlet_o[5:0] == 6'h03);
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset value");

  // a request is answered on the next edge
  property p_ack_lat;
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");

  // ack is a single-cycle pulse
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

  // flag byte write lands on the flags
  property p_flags_wr;
    @(posedge clk_i) disable iff (rst_i)
    (req_live && hit && we_i && sel_i[3] && !soft_rst_i)
      |=> quadlet_o[31:27] == $past(dat_i[31:27]);
  endproperty
  a_flags_wr: assert property (p_flags_wr) else $error("flag write lost");

  // reserved bits and speed never change
  property p_rsv_zero;
    @(posedge clk_i) disable iff (rst_i)
    ##1 (quadlet_o[26:24] == 3'h0) && (quadlet_o[11:8] == 4'h0) && (quadlet_o[5:0] == 6'h03);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");

  // accuracy byte write lands
  property p_acc_wr;
    @(posedge clk_i) disable iff (rst_i)
    (req_live && hit && we_i && sel_i[2] && !soft_rst_i)
      |=> quadlet_o[23:16] == $past(dat_i[23:16]);
  endproperty
  a_acc_wr: assert property (p_acc_wr) else $error("accuracy write lost");

  // size code byte write lands on the code
  property p_rec_wr;
    @(posedge clk_i) disable iff (rst_i)
    (req_live && hit && we_i && sel_i[1] && !soft_rst_i)
      |=> quadlet_o[15:12] == $past(dat_i[15:12]);
  endproperty
  a_rec_wr: assert property (p_rec_wr) else $error("size code write lost");

  // without a write or a soft reset the quadlet holds still
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    !(req_live && hit && we_i) && !soft_rst_i |=> $stable(quadlet_o);
  endproperty
  a_hold: assert property (p_hold) else $error("quadlet changed unasked");

  // soft reset clears flags yet keeps the size code
  property p_soft_keep;
    @(posedge clk_i) disable iff (rst_i)
    soft_rst_i |=> (quadlet_o[31:27] == 5'h00) && (quadlet_o[23:16] == 8'h00)
      && (quadlet_o[15:12] == $past(quadlet_o[15:12]));
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset hit code");

  // read data matches the register at ack
  property p_rd_data;
    @(posedge clk_i) disable iff (rst_i)
    (req_live && !we_i) |=> ack_o && (dat_o == ($past(hit) ? $past(quadlet_o) : 32'h0));
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");

  // byte limit follows the code
  property p_limit;
    @(posedge clk_i) disable iff (rst_i)
    ##1 rec_bytes_o == (17'h00002 << quadlet_o[15:12]);
  endproperty
  a_limit: assert property (p_limit) else $error("byte limit wrong");

  // verdict a cycle later, error only above the limit
  property p_verdict;
    @(posedge clk_i) disable iff (rst_i)
    req_i.valid |=> verdict_o.valid
      && (verdict_o.type_err == ($past(req_i.len) > $past(rec_bytes_o)));
  endproperty
  a_verdict: assert property (p_verdict) else $error("length verdict wrong");

  // no verdict without a request
  property p_no_verdict;
    @(posedge clk_i) disable iff (rst_i)
    !req_i.valid |=> !verdict_o.valid && !verdict_o.type_err;
  endproperty
  a_no_verdict: assert property (p_no_verdict) else $error("spurious verdict");

endmodule : bor_top

// ---- tb/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bor_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // ordinary cases: one write, then the quadlet it must leave behind
  typedef struct packed {
    logic [31:0] dat;  // write data
    logic [3:0]  sel;  // byte enables
    logic [31:0] exp;  // expected quadlet after the write
  } bor_row_t;

  logic        clk_i;        // 100 mhz
  logic        rst_i;        // hardware reset
  logic        soft_rst_i;   // software reset
  logic        cyc_i;        // bus cycle
  logic        stb_i;        // bus strobe
  logic        we_i;         // write enable
  logic [7:0]  adr_i;        // byte address
  logic [3:0]  sel_i;        // byte enables
  logic [31:0] dat_i;        // write data
  logic [31:0] dat_o;        // read data
  logic        ack_o;        // bus answer
  bor_req_t    req_i;        // block write length offered
  bor_verdict_t verdict_o;   // length verdict
  logic [31:0] quadlet_o;    // remote quadlet view
  logic [16:0] rec_bytes_o;  // byte limit
  logic [31:0] rd;           // last read data
  logic [16:0] lim;          // byte limit of the current row
  int          miscompares;  // mismatches seen
  int          checks;       // comparisons made
  bor_row_t    rows [6];     // case table

  bor_top u_bor_top (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .req_i(req_i),
    .verdict_o(verdict_o), .quadlet_o(quadlet_o), .rec_bytes_o(rec_bytes_o));

  // free-running clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // one comparison of any value up to a word wide
  task chk(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  // classic single cycle; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s,
          input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      results();
    end
  endtask : wb

  // two block write lengths on back-to-back cycles, verdict one cycle later
  task lens(input logic [16:0] la, input logic [16:0] lb,
            input logic ea, input logic eb);
    @(posedge clk_i);
    req_i <= '{valid: 1'b1, len: la};
    @(posedge clk_i);
    req_i <= '{valid: 1'b1, len: lb};
    @(posedge clk_i);
    req_i <= '0;
    chk({30'h0, 1'b1, ea}, {30'h0, verdict_o});
    @(posedge clk_i);
    chk({30'h0, 1'b1, eb}, {30'h0, verdict_o});
  endtask : lens

  // hardware reset held for sixteen cycles
  task hw_reset;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : hw_reset

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    soft_rst_i = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    req_i = '0;
    miscompares = 0;
    checks = 0;
    // cumulative: each row starts from the previous row's quadlet
    // every row leaves valid fields and a limit of 512 or more
    rows[0] = '{32'hffffffff, 4'hf, 32'hf8fff0c3};
    rows[1] = '{32'h00000000, 4'h4, 32'hf800f0c3};
    rows[2] = '{32'h12345678, 4'h8, 32'h1000f0c3};
    rows[3] = '{32'h00009500, 4'h2, 32'h100090c3};
    rows[4] = '{32'h0000003c, 4'h1, 32'h10009003};
    rows[5] = '{32'h08a58000, 4'hf, 32'h08a58003};
    hw_reset();
    chk(32'h0000b003, quadlet_o);
    chk(32'd4096, {15'h0, rec_bytes_o});
    wb(1'b0, 8'h20, 4'hf, 32'h0);
    chk(32'h0000b003, rd);
    lens(17'd4096, 17'd4097, 1'b0, 1'b1);
    // table of writes, each read back and length-checked at its limit
    foreach (rows[i])
    begin
      wb(1'b1, 8'h20, rows[i].sel, rows[i].dat);
      chk(rows[i].exp, quadlet_o);
      wb(1'b0, 8'h20, 4'hf, 32'h0);
      chk(rows[i].exp, rd);
      lim = 17'h1 << (rows[i].exp[15:12] + 1);
      chk({15'h0, lim}, {15'h0, rec_bytes_o});
      lens(lim, lim + 17'd1, 1'b0, 1'b1);
    end
    // unmapped place ignores writes and reads zero
    wb(1'b1, 8'h24, 4'hf, 32'hffffffff);
    chk(32'h08a58003, quadlet_o);
    wb(1'b0, 8'h24, 4'hf, 32'h0);
    chk(32'h0, rd);
    // low address bits do not take part in the decode
    wb(1'b0, 8'h23, 4'hf, 32'h0);
    chk(32'h08a58003, rd);
    // software reset clears the flags and accuracy, keeps the size code
    wb(1'b1, 8'h20, 4'hf, 32'hffffffff);
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'h0000f003, quadlet_o);
    chk(32'd65536, {15'h0, rec_bytes_o});
    // a second hardware reset in mid-run brings the size code back
    hw_reset();
    chk(32'h0000b003, quadlet_o);
    lens(17'd4097, 17'd1, 1'b1, 1'b0);
    results();
  end
endmodule : testbench
